// ---- verilog/dsmap_defs.svh ----
// Constants of the DS3 to STS-1 envelope mapper and demapper
//
// Behaviour
// - Overhead fills first three columns, 27 bytes
// - Envelope is 87x9 bytes, floats across frames
// - First envelope column is path overhead
// - 59 filler bits per row, ignored
// - 621 DS3 data bits per row
// - One stuff opportunity bit per row
// - Five stuff control bits per row
// - Control all zero: opportunity carries data
// - Control all one: opportunity is junk
// - Two communication bits per row, user visible
// - Pointer bytes locate envelope, flag adjustments
// - Frame is 810 bytes, 9 by 90
// - Bytes sent row by row, leftmost first
// - Nominal rate uses three opportunities per envelope
`ifndef DSMAP_DEFS_SVH
`define DSMAP_DEFS_SVH

// ==========================================================
// Frame geometry
`define DSMAP_LAST_ROW    4'd8
`define DSMAP_LAST_COL    7'd89
`define DSMAP_TOH_COLS    7'd3
`define DSMAP_FIRST_PAY   7'd4
`define DSMAP_SPE_COLS    10'd87
`define DSMAP_SPE_LAST    7'd86
`define DSMAP_ROW_WRAP    4'd6
`define DSMAP_FRAME_BITS  13'd6480
`define DSMAP_FRAME_RATE  8000

// ==========================================================
// Overhead bytes
`define DSMAP_FRAME_ROW   4'd0
`define DSMAP_PTR_ROW     4'd3
`define DSMAP_A1          8'hf6
`define DSMAP_A2          8'h28
`define DSMAP_NDF_NORM    4'h6
`define DSMAP_NDF_SET     4'h9
`define DSMAP_PTR_MAX     10'd782
`define DSMAP_TX_PTR      10'h000
`define DSMAP_POH_BYTE    8'h00

// ==========================================================
// Bit layout of one envelope payload row (688 bits)
`define DSMAP_POS_OH0     10'd0
`define DSMAP_POS_OH1     10'd1
`define DSMAP_POS_C0      10'd2
`define DSMAP_POS_FIX0    10'd7
`define DSMAP_POS_SOPP    10'd66
`define DSMAP_POS_DATA0   10'd67
`define DSMAP_CTRL_MAJ    3'd3

// ==========================================================
// Rate justification
`define DSMAP_FIFO_DEPTH  4
`define DSMAP_STUFF_TH    3'd2

`endif

// ---- verilog/dsmap_pkg.sv ----
// Types shared by the envelope mapper files
package dsmap_pkg;

  // ==========================================================
  // Bit classes within a frame
  typedef enum logic [6:0] {
    K_TOH  = 7'h01,
    K_POH  = 7'h02,
    K_FIX  = 7'h04,
    K_DATA = 7'h08,
    K_SOPP = 7'h10,
    K_CTRL = 7'h20,
    K_OH   = 7'h40
  } dsmap_kind_e;

  typedef enum logic [1:0] {
    LOCK_LOST = 2'h1,
    LOCK_HELD = 2'h2
  } dsmap_lock_e;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic [3:0] row;
    logic [6:0] col;
    logic [2:0] bitn;
  } dsmap_pos_s;

  typedef struct packed {
    logic data;
    logic fs;
  } dsmap_line_s;

  typedef struct packed {
    logic       ptr_adj;
    logic       ndf;
    logic       oh_stb;
    logic [1:0] oh;
  } dsmap_rx_evt_s;

  // ==========================================================
  // Whole state of the core except the justification FIFO
  typedef struct packed {
    dsmap_pos_s    tx_pos;
    logic          tx_stuff;
    dsmap_line_s   tx_line;
    logic          tx_under;
    logic [12:0]   chk_cnt;
    logic          chk_seen;
    dsmap_pos_s    rx_pos;
    logic          rx_run;
    logic [7:0]    rx_sh;
    logic [7:0]    rx_h1;
    logic [9:0]    rx_ptr;
    dsmap_lock_e   rx_lock;
    logic          rx_spe_on;
    logic [6:0]    rx_spe_col;
    logic [2:0]    rx_ccnt;
    logic          rx_data;
    logic          rx_valid;
    dsmap_rx_evt_s rx_evt;
  } dsmap_state_s;

endpackage : dsmap_pkg

// ---- verilog/dsmap_fifo.sv ----
// Small flop FIFO for the DS3 bits awaiting mapping
`timescale 1ns/1ps
module dsmap_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic                       ref_clk,
  input  wire logic                       sys_rst,
  // Fill side
  input  wire logic                       in_valid,
  output logic                            in_ready,
  input  wire logic [WIDTH-1:0]           in_data,
  // Drain side
  output logic                            out_valid,
  input  wire logic                       out_ready,
  output logic [WIDTH-1:0]                out_data,
  output logic [$clog2(DEPTH):0]          count
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               rp;
    logic [AW-1:0]               wp;
    logic [AW:0]                 cnt;
  } dsmap_fifo_st_s;

  dsmap_fifo_st_s s_q;
  dsmap_fifo_st_s s_d;
  logic           push;
  logic           pop;

  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    return (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction : ptr_inc

  assign in_ready  = (s_q.cnt != (AW + 1)'(DEPTH));
  assign out_valid = (s_q.cnt != '0);
  assign out_data  = s_q.mem[s_q.rp];
  assign count     = s_q.cnt;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.mem[s_q.wp] = in_data;
      s_d.wp          = ptr_inc(s_q.wp);
    end
    if (pop) begin
      s_d.rp = ptr_inc(s_q.rp);
    end
    if (push && !pop) begin
      s_d.cnt = s_q.cnt + (AW + 1)'(1);
    end else if (pop && !push) begin
      s_d.cnt = s_q.cnt - (AW + 1)'(1);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule : dsmap_fifo

// ---- verilog/dsmap_core.sv ----
// DS3 into STS-1 envelope mapper and demapper, one line bit per clock
`timescale 1ns/1ps
`include "dsmap_defs.svh"
module dsmap_core import dsmap_pkg::*; (
  // Clock and reset
  input  wire logic          ref_clk,
  input  wire logic          sys_rst,
  // DS3 bits to be mapped
  input  wire logic          ds3_tx_data,
  input  wire logic          ds3_tx_valid,
  output logic               ds3_tx_ready,
  input  wire logic [1:0]    tx_oh,
  // STS-1 line
  output dsmap_line_s        sts_tx,
  input  wire dsmap_line_s   sts_rx,
  // Demapped DS3 bits and events
  output logic               ds3_rx_data,
  output logic               ds3_rx_valid,
  output dsmap_rx_evt_s      rx_evt,
  output logic               rx_locked,
  output logic               tx_underrun
);

  // ==========================================================
  // Helpers
  // Named copy of the fixed pointer so its fields can be sliced
  localparam logic [9:0] tx_ptr_fixed = `DSMAP_TX_PTR;

  function automatic dsmap_pos_s pos_next(input dsmap_pos_s p);
    dsmap_pos_s n;
    n = p;
    if (p.bitn != 3'd7) begin
      n.bitn = p.bitn + 3'd1;
    end else begin
      n.bitn = 3'd0;
      if (p.col != `DSMAP_LAST_COL) begin
        n.col = p.col + 7'd1;
      end else begin
        n.col = 7'd0;
        n.row = (p.row == `DSMAP_LAST_ROW) ? 4'd0 : p.row + 4'd1;
      end
    end
    return n;
  endfunction : pos_next

  // Byte index in the envelope capacity, zero just after the third pointer byte
  function automatic logic [9:0] env_index(input dsmap_pos_s p);
    logic [3:0] rr;
    rr = (p.row >= `DSMAP_PTR_ROW) ? p.row - `DSMAP_PTR_ROW : p.row + `DSMAP_ROW_WRAP;
    return 10'(rr) * `DSMAP_SPE_COLS + 10'(p.col) - 10'(`DSMAP_TOH_COLS);
  endfunction : env_index

  function automatic dsmap_kind_e bit_kind(input logic [9:0] pp);
    if (pp < `DSMAP_POS_C0) begin
      return K_OH;
    end else if (pp < `DSMAP_POS_FIX0) begin
      return K_CTRL;
    end else if (pp < `DSMAP_POS_SOPP) begin
      return K_FIX;
    end else if (pp == `DSMAP_POS_SOPP) begin
      return K_SOPP;
    end else begin
      return K_DATA;
    end
  endfunction : bit_kind

  // ==========================================================
  // Justification FIFO
  dsmap_state_s s_q;
  dsmap_state_s s_d;
  logic         fifo_valid;
  logic         fifo_data;
  logic [2:0]   fifo_count;
  logic         tx_pop;

  dsmap_fifo #(
    .WIDTH (1),
    .DEPTH (`DSMAP_FIFO_DEPTH)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .sys_rst   (sys_rst),
    .in_valid  (ds3_tx_valid),
    .in_ready  (ds3_tx_ready),
    .in_data   (ds3_tx_data),
    .out_valid (fifo_valid),
    .out_ready (tx_pop),
    .out_data  (fifo_data),
    .count     (fifo_count)
  );

  // ==========================================================
  // Next state
  dsmap_pos_s  tp;
  dsmap_kind_e tx_kind;
  logic [9:0]  tx_pp;
  logic [7:0]  toh_byte;
  logic        stuff_now;
  logic        need_bit;
  logic        tx_bit;
  dsmap_pos_s  rp;
  logic [7:0]  sh;
  logic [9:0]  rx_ptr_new;
  logic [6:0]  sc;
  logic        spe_on;
  logic [9:0]  rx_pp;
  dsmap_kind_e rx_kind;

  always_comb begin
    s_d = s_q;
    // Transmit frame, pointer fixed so the envelope starts after the third pointer byte
    tp       = s_q.tx_pos;
    tx_pp    = {7'(tp.col - `DSMAP_FIRST_PAY), tp.bitn};
    toh_byte = 8'h00;
    if (tp.col < `DSMAP_TOH_COLS) begin
      tx_kind = K_TOH;
      if (tp.row == `DSMAP_FRAME_ROW && tp.col == 7'd0) begin
        toh_byte = `DSMAP_A1;
      end else if (tp.row == `DSMAP_FRAME_ROW && tp.col == 7'd1) begin
        toh_byte = `DSMAP_A2;
      end else if (tp.row == `DSMAP_PTR_ROW && tp.col == 7'd0) begin
        toh_byte = {`DSMAP_NDF_NORM, 2'b00, tx_ptr_fixed[9:8]};
      end else if (tp.row == `DSMAP_PTR_ROW && tp.col == 7'd1) begin
        toh_byte = tx_ptr_fixed[7:0];
      end
    end else if (tp.col == `DSMAP_TOH_COLS) begin
      tx_kind  = K_POH;
      toh_byte = `DSMAP_POH_BYTE;
    end else begin
      tx_kind = bit_kind(tx_pp);
    end
    // Decide at the first control bit from FIFO fill; keeps long-run rate matched
    stuff_now = s_q.tx_stuff;
    if (tx_kind == K_CTRL && tx_pp == `DSMAP_POS_C0) begin
      stuff_now = (fifo_count < `DSMAP_STUFF_TH);
    end
    s_d.tx_stuff = stuff_now;
    need_bit = (tx_kind == K_DATA) || (tx_kind == K_SOPP && !stuff_now);
    tx_pop   = need_bit && fifo_valid;
    case (tx_kind)
      K_TOH, K_POH: tx_bit = toh_byte[3'd7 - tp.bitn];
      K_CTRL:       tx_bit = stuff_now;
      K_OH:         tx_bit = tx_pp[0] ? tx_oh[0] : tx_oh[1];
      K_DATA:       tx_bit = fifo_valid & fifo_data;
      K_SOPP:       tx_bit = stuff_now ? 1'b0 : (fifo_valid & fifo_data);
      default:      tx_bit = 1'b0;
    endcase
    s_d.tx_pos       = pos_next(tp);
    s_d.tx_line.data = tx_bit;
    s_d.tx_line.fs   = (tp == '0);
    s_d.tx_under     = need_bit && !fifo_valid;
    s_d.chk_cnt      = (tp == '0) ? 13'd0 : s_q.chk_cnt + 13'd1;
    s_d.chk_seen     = s_q.chk_seen | (tp == '0);

    // Receive side, aligned by the framer's frame start
    s_d.rx_valid       = 1'b0;
    s_d.rx_evt.ptr_adj = 1'b0;
    s_d.rx_evt.ndf     = 1'b0;
    s_d.rx_evt.oh_stb  = 1'b0;
    rp         = sts_rx.fs ? '0 : s_q.rx_pos;
    sh         = {s_q.rx_sh[6:0], sts_rx.data};
    rx_ptr_new = {s_q.rx_h1[1:0], sh};
    sc         = s_q.rx_spe_col;
    spe_on     = s_q.rx_spe_on;
    rx_pp      = {7'(sc - 7'd1), rp.bitn};
    rx_kind    = bit_kind(rx_pp);
    if (s_q.rx_run || sts_rx.fs) begin
      s_d.rx_run = 1'b1;
      s_d.rx_pos = pos_next(rp);
      s_d.rx_sh  = sh;
      if (rp.col < `DSMAP_TOH_COLS) begin
        if (rp.bitn == 3'd7 && rp.row == `DSMAP_PTR_ROW && rp.col == 7'd0) begin
          s_d.rx_h1 = sh;
        end else if (rp.bitn == 3'd7 && rp.row == `DSMAP_PTR_ROW && rp.col == 7'd1) begin
          s_d.rx_evt.ndf = (s_q.rx_h1[7:4] == `DSMAP_NDF_SET);
          if (rx_ptr_new <= `DSMAP_PTR_MAX) begin
            s_d.rx_evt.ptr_adj = (s_q.rx_lock == LOCK_HELD) && (rx_ptr_new != s_q.rx_ptr);
            s_d.rx_ptr         = rx_ptr_new;
            s_d.rx_lock        = LOCK_HELD;
          end else begin
            s_d.rx_lock   = LOCK_LOST;
            s_d.rx_spe_on = 1'b0;
          end
        end
      end else begin
        if (rp.bitn == 3'd0) begin
          if (s_q.rx_lock == LOCK_HELD && env_index(rp) == s_q.rx_ptr) begin
            sc     = 7'd0;
            spe_on = 1'b1;
          end else if (sc == `DSMAP_SPE_LAST) begin
            sc = 7'd0;
          end else begin
            sc = sc + 7'd1;
          end
        end
        s_d.rx_spe_col = sc;
        s_d.rx_spe_on  = spe_on;
        rx_pp          = {7'(sc - 7'd1), rp.bitn};
        rx_kind        = bit_kind(rx_pp);
        if (spe_on && sc != 7'd0) begin
          case (rx_kind)
            K_CTRL: begin
              s_d.rx_ccnt = (rx_pp == `DSMAP_POS_C0) ? {2'b00, sts_rx.data}
                                                      : s_q.rx_ccnt + {2'b00, sts_rx.data};
            end
            K_SOPP: begin
              s_d.rx_valid = (s_q.rx_ccnt < `DSMAP_CTRL_MAJ);
              s_d.rx_data  = sts_rx.data;
            end
            K_DATA: begin
              s_d.rx_valid = 1'b1;
              s_d.rx_data  = sts_rx.data;
            end
            K_OH: begin
              if (rx_pp == `DSMAP_POS_OH0) begin
                s_d.rx_evt.oh[1] = sts_rx.data;
              end else begin
                s_d.rx_evt.oh[0] = sts_rx.data;
                s_d.rx_evt.oh_stb = 1'b1;
              end
            end
            default: begin
            end
          endcase
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      s_q         <= '0;
      s_q.rx_lock <= LOCK_LOST;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // Outputs
  assign sts_tx       = s_q.tx_line;
  assign tx_underrun  = s_q.tx_under;
  assign ds3_rx_data  = s_q.rx_data;
  assign ds3_rx_valid = s_q.rx_valid;
  assign rx_evt       = s_q.rx_evt;
  assign rx_locked    = (s_q.rx_lock == LOCK_HELD);

  // ==========================================================
  // Checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  sequence s_a1_pattern;
    sts_tx.data [*4] ##1 !sts_tx.data ##1 sts_tx.data [*2] ##1 !sts_tx.data;
  endsequence

  a_frame_align: assert property (sts_tx.fs |-> s_a1_pattern)
    else $error("frame start not followed by first framing byte");
  a_frame_len: assert property ((tp == '0 && s_q.chk_seen) |-> s_q.chk_cnt == `DSMAP_FRAME_BITS - 13'd1)
    else $error("frame length wrong");
  a_ctrl_steady: assert property ((tx_kind == K_CTRL && tx_pp != `DSMAP_POS_C0) |=>
                                   sts_tx.data == $past(s_q.tx_stuff))
    else $error("control bits differ within a row");
  a_stuff_junk: assert property ((tx_kind == K_SOPP && s_q.tx_stuff) |-> !tx_pop)
    else $error("data taken at a stuffed opportunity");
  a_ctrl_zero_pop: assert property ((tx_kind == K_SOPP && !s_q.tx_stuff && fifo_valid) |-> tx_pop)
    else $error("data not placed at an open opportunity");
  a_data_pop: assert property ((tx_kind == K_DATA) |-> (tx_pop == fifo_valid) ##1 (tx_underrun == !$past(fifo_valid)))
    else $error("data position did not take a bit");
  a_fill_no_pop: assert property ((tx_kind == K_FIX || tx_kind == K_POH || tx_kind == K_TOH) |-> !tx_pop)
    else $error("bit taken outside a data position");
  a_vote_discard: assert property ((s_q.rx_spe_on && rx_kind == K_SOPP && s_q.rx_ccnt >= `DSMAP_CTRL_MAJ
                                    && rp.col > `DSMAP_TOH_COLS && !sts_rx.fs && rp.bitn != 3'd0) |=> !ds3_rx_valid)
    else $error("voted stuff bit delivered");
  a_adj_locked: assert property (rx_evt.ptr_adj |-> rx_locked ##1 !rx_evt.ptr_adj)
    else $error("pointer event without lock");

endmodule : dsmap_core

// ---- verif/dsmap_line_model.sv ----
// Far-end line model: loops the transmit line back with one register of delay
`timescale 1ns/1ps
module dsmap_line_model import dsmap_pkg::*; (
  // Clock
  input  wire logic        ref_clk,
  // Line
  input  wire dsmap_line_s tx_line,
  output dsmap_line_s      rx_line,
  // Fault command
  input  wire logic        flip_en
);
  int pos;

  // ==========================================================
  // Loopback, frame pulse kept in step with its bit
  always @(posedge ref_clk) begin
    pos = tx_line.fs ? 0 : pos + 1;
    rx_line.fs <= tx_line.fs;
    // First control bit of every row corrupted, vote must mask it
    rx_line.data <= tx_line.data ^ (flip_en && (pos % 720) == 34);
  end
endmodule : dsmap_line_model

// ---- verif/dsmap_core_tb_top.sv ----
// Self-checking bench: DS3 mapper looped back through a line model
`timescale 1ns/1ps
module dsmap_core_tb_top import dsmap_pkg::*;;
  logic          ref_clk      = 1'b0;
  logic          sys_rst      = 1'b1;
  logic          ds3_tx_data  = 1'b0;
  logic          ds3_tx_valid = 1'b0;
  logic          flip_en      = 1'b0;
  logic [1:0]    tx_oh        = 2'h0;
  logic          ds3_tx_ready;
  logic          ds3_rx_data;
  logic          ds3_rx_valid;
  logic          rx_locked;
  logic          tx_underrun;
  dsmap_line_s   sts_tx;
  dsmap_line_s   sts_rx;
  dsmap_rx_evt_s rx_evt;
  int            num_errors   = 0;
  int            comparisons  = 0;
  int            p            = 0;
  int            r, q, stage  = 0;
  int            stuffs       = 0;
  int            full_seen    = 0;
  int            under_seen   = 0;
  bit            seen         = 0;
  bit            rx_on        = 0;
  bit            slow         = 0;
  logic [4:0]    ctrl         = 5'h00;
  logic [7:0]    sh           = 8'h00;
  logic [8:0]    e;
  logic          q_in[$];
  logic          q_rx[$];

  dsmap_core u_dsmap_core (
    .ref_clk      (ref_clk),
    .sys_rst      (sys_rst),
    .ds3_tx_data  (ds3_tx_data),
    .ds3_tx_valid (ds3_tx_valid),
    .ds3_tx_ready (ds3_tx_ready),
    .tx_oh        (tx_oh),
    .sts_tx       (sts_tx),
    .sts_rx       (sts_rx),
    .ds3_rx_data  (ds3_rx_data),
    .ds3_rx_valid (ds3_rx_valid),
    .rx_evt       (rx_evt),
    .rx_locked    (rx_locked),
    .tx_underrun  (tx_underrun)
  );

  dsmap_line_model u_dsmap_line_model (
    .ref_clk (ref_clk),
    .tx_line (sts_tx),
    .rx_line (sts_rx),
    .flip_en (flip_en)
  );

  always #4 ref_clk = ~ref_clk;

  // ==========================================================
  // Helpers
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // Expected overhead byte by frame byte index, bit 8 marks a checked byte
  function automatic logic [8:0] exp_oh(input int b);
    if (b % 90 > 3) return 9'h000;
    if (b == 0) return 9'h1f6;
    if (b == 1) return 9'h128;
    if (b == 270) return 9'h160;
    return 9'h100;
  endfunction : exp_oh

  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test

  // ==========================================================
  // Stimulus and line monitor, one process so position never races
  always @(posedge ref_clk) begin
    if (ds3_tx_valid && ds3_tx_ready) q_in.push_back(ds3_tx_data);
    if (!ds3_tx_ready) full_seen++;
    if (tx_underrun) under_seen++;
    if (ds3_rx_valid) begin
      check(8'(rx_on && q_rx.size() > 0), 8'h01);
      if (q_rx.size() > 0) check(8'(ds3_rx_data), 8'(q_rx.pop_front()));
    end
    if (rx_on) check(8'({rx_locked, rx_evt.ptr_adj, rx_evt.ndf}), 8'h04);
    if (rx_on && rx_evt.oh_stb) check(8'(rx_evt.oh), 8'(tx_oh));
    if (seen) check(8'(sts_tx.fs), 8'(p == 6479));
    if (sts_tx.fs) seen = 1;
    p = sts_tx.fs ? 0 : p + 1;
    r = p % 720;
    q = r - 32;
    if (seen) begin
      sh = {sh[6:0], sts_tx.data};
      e = exp_oh(p / 8);
      if (p % 8 == 7 && e[8]) check(sh, e[7:0]);
      if (r == 24 && p / 720 == 3) begin
        if (stage == 0) stage = 1;
        if (rx_locked) rx_on = 1;
      end
    end
    if (stage > 0) begin
      if (q == 0 || q == 1) check(8'(sts_tx.data), 8'(tx_oh[1 - q]));
      if (q >= 2 && q <= 6) ctrl = {ctrl[3:0], sts_tx.data};
      if (q == 7) check(8'(ctrl == 5'h00 || ctrl == 5'h1f), 8'h01);
      if (q == 66 && ctrl == 5'h1f) stuffs++;
      if (q >= 67 || (q == 66 && ctrl == 5'h00)) begin
        if (stage == 1) check(8'(sts_tx.data), 8'(q_in.pop_front()));
        if (rx_on) q_rx.push_back(sts_tx.data);
      end
    end
    if (stage == 1) check(8'(tx_underrun), 8'h00);
    // Starve the buffer across a row end so the next row must stuff
    if (r == 700) slow = ($urandom % 3 == 0);
    ds3_tx_valid <= (stage == 1) && !(slow && (r >= 716 || r < 40));
    ds3_tx_data  <= 1'($urandom);
  end

  // ==========================================================
  // Phases
  initial begin
    void'($urandom(78));
    tx_oh <= 2'($urandom);
    repeat (4) @(posedge ref_clk);
    sys_rst <= 1'b0;
    wait (stage == 1);
    repeat (2 * 6480) @(posedge ref_clk);
    flip_en <= 1'b1;
    repeat (2 * 6480) @(posedge ref_clk);
    // Source goes silent: data slots must underrun and stuff
    stage = 2;
    repeat (1500) @(posedge ref_clk);
    check(8'(under_seen > 0), 8'h01);
    check(8'(full_seen > 0), 8'h01);
    check(8'(stuffs > 0), 8'h01);
    check(8'(q_rx.size() < 700), 8'h01);
    end_of_test();
  end

  initial begin
    repeat (40000) @(posedge ref_clk);
    num_errors++;
    end_of_test();
  end
endmodule : dsmap_core_tb_top
